// [logic/bal_pkg.sv]
// Shared constants and types for the byte ALU: register map, instruction
// layout, operation codes, flag layout and reset values.
// Assumes a 32-bit AHB-Lite bus and an 8-bit data path.
package bal_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] BAL_REG_INSTR = 8'h00;
   localparam logic [7:0] BAL_REG_ACC = 8'h04;
   localparam logic [7:0] BAL_REG_STATUS = 8'h08;
   localparam logic [7:0] BAL_REG_DIR = 8'h0C;
   localparam logic [7:0] BAL_REG_FADDR = 8'h10;
   localparam logic [7:0] BAL_REG_FDATA = 8'h14;

   // ----------------------------------------------------------------
   // Sizes, operands and reset values
   // ----------------------------------------------------------------
   localparam int BAL_FILE_AW = 7;
   localparam int BAL_FILE_DEPTH = 128;
   localparam int BAL_NUM_PORTS = 3;
   localparam logic [6:0] BAL_DIR_FIRST = 7'h05;
   localparam logic [7:0] BAL_DIR_RESET = 8'hFF;
   localparam logic [7:0] BAL_ACC_RESET = 8'h00;
   localparam logic [31:0] BAL_WORD_ZERO = 32'h0000_0000;
   localparam logic [1:0] BAL_HRESP_OKAY = 2'h0;

   // ----------------------------------------------------------------
   // Operation codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      BAL_OP_NOP = 3'h0,
      BAL_OP_SUBB = 3'h1,
      BAL_OP_SWAP = 3'h2,
      BAL_OP_DIRLD = 3'h3,
      BAL_OP_XORL = 3'h4,
      BAL_OP_XORF = 3'h5
   } bal_op_type;

   // ----------------------------------------------------------------
   // Instruction word and status flags
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic [7:0] pad_hi;
      logic [7:0] literal;
      logic pad_mid;
      logic [6:0] faddr;
      logic [3:0] pad_lo;
      logic dest;
      logic [2:0] op;
   } bal_instr_type;

   typedef struct packed
   {
      logic z;
      logic dc;
      logic c;
   } bal_flags_type;

   localparam bal_flags_type BAL_FLAGS_RESET = 3'h0;

endpackage

// [logic/bal_file_ram.sv]
// File register memory of the byte ALU: one port, synchronous write,
// registered read data.
// Assumes address and write strobe come from logic on the same clock.
`timescale 1ns/1ps
module bal_file_ram
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Access port
   input wire logic [bal_pkg::BAL_FILE_AW-1:0] addr,
   input wire logic wen,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);

   logic [7:0] mem [bal_pkg::BAL_FILE_DEPTH];

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (wen)
      begin
         mem[addr] <= wdata;
      end
   end

   // Read gives the old contents when read and write meet
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         rdata <= 8'h00;
      end
      else
      begin
         rdata <= mem[addr];
      end
   end

endmodule

// [logic/bal_alu.sv]
// Byte ALU with AHB-Lite register access: executes one instruction per
// write to the instruction register against the accumulator, the status
// flags, a file register memory and three port direction registers.
// Assumes a single AHB-Lite master and whole-word transfers.
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module bal_alu
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic [1:0] hresp,
   // Port direction registers
   output logic [7:0] port_a_direction,
   output logic [7:0] port_b_direction,
   output logic [7:0] port_c_direction
);

   typedef enum {ST_IDLE, ST_DATA, ST_RDATA, ST_EXRD, ST_EXWB} bal_state_type;

   bal_state_type state;
   bal_state_type next_state;
   logic next_hreadyout;
   logic [31:0] next_hrdata;
   logic [7:0] addr_q;
   logic [7:0] next_addr_q;
   logic write_q;
   logic next_write_q;
   bal_pkg::bal_instr_type instr;
   bal_pkg::bal_instr_type next_instr;
   logic [6:0] file_addr;
   logic [6:0] next_file_addr;
   logic [7:0] acc;
   logic [7:0] next_acc;
   bal_pkg::bal_flags_type flags;
   bal_pkg::bal_flags_type next_flags;
   logic [7:0] dir [bal_pkg::BAL_NUM_PORTS];
   logic [6:0] mem_addr;
   logic mem_wen;
   logic [7:0] mem_wdata;
   logic [7:0] mem_rdata;
   logic [8:0] sub_sum;
   logic [4:0] sub_nib;
   logic [7:0] xor_file;
   logic [7:0] swap_res;
   logic wb;
   logic accept;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == 8'h00);
   endfunction

   function automatic logic dir_hit(input logic [6:0] f, input int idx);
      dir_hit = (f == 7'(bal_pkg::BAL_DIR_FIRST + 7'(idx)));
   endfunction

   assign accept = hsel && htrans[1] && hready;
   assign wb = (state == ST_EXWB);

   // ----------------------------------------------------------------
   // File register memory
   // ----------------------------------------------------------------
   bal_file_ram u_ram
   (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .addr(mem_addr),
      .wen(mem_wen),
      .wdata(mem_wdata),
      .rdata(mem_rdata)
   );

   // ----------------------------------------------------------------
   // Bus and sequencing
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      next_hreadyout = hreadyout;
      next_hrdata = hrdata;
      next_addr_q = addr_q;
      next_write_q = write_q;
      next_instr = instr;
      next_file_addr = file_addr;
      case (state)
         ST_IDLE:
         begin
            if (accept)
            begin
               next_state = ST_DATA;
               next_hreadyout = 1'b0;
               next_addr_q = haddr[7:0];
               next_write_q = hwrite;
            end
         end
         ST_DATA:
         begin
            if (!write_q)
            begin
               next_state = ST_RDATA;
            end
            else if (addr_q == bal_pkg::BAL_REG_INSTR)
            begin
               next_instr = bal_pkg::bal_instr_type'(hwdata);
               next_state = ST_EXRD;
            end
            else
            begin
               if (addr_q == bal_pkg::BAL_REG_FADDR)
               begin
                  next_file_addr = hwdata[6:0];
               end
               next_state = ST_IDLE;
               next_hreadyout = 1'b1;
            end
         end
         ST_RDATA:
         begin
            case (addr_q)
               bal_pkg::BAL_REG_INSTR: next_hrdata = instr;
               bal_pkg::BAL_REG_ACC: next_hrdata = {24'h00_0000, acc};
               bal_pkg::BAL_REG_STATUS: next_hrdata = {29'h0000_0000, flags};
               bal_pkg::BAL_REG_DIR: next_hrdata = {8'h00, dir[2], dir[1], dir[0]};
               bal_pkg::BAL_REG_FADDR: next_hrdata = {25'h000_0000, file_addr};
               bal_pkg::BAL_REG_FDATA: next_hrdata = {24'h00_0000, mem_rdata};
               default: next_hrdata = bal_pkg::BAL_WORD_ZERO;
            endcase
            next_state = ST_IDLE;
            next_hreadyout = 1'b1;
         end
         ST_EXRD:
         begin
            next_state = ST_EXWB;
         end
         ST_EXWB:
         begin
            next_state = ST_IDLE;
            next_hreadyout = 1'b1;
         end
         default:
         begin
            next_state = ST_IDLE;
            next_hreadyout = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= ST_IDLE;
         hreadyout <= 1'b1;
         hrdata <= bal_pkg::BAL_WORD_ZERO;
         hresp <= bal_pkg::BAL_HRESP_OKAY;
         addr_q <= 8'h00;
         write_q <= 1'b0;
         instr <= bal_pkg::BAL_WORD_ZERO;
         file_addr <= 7'h00;
      end
      else
      begin
         state <= next_state;
         hreadyout <= next_hreadyout;
         hrdata <= next_hrdata;
         hresp <= bal_pkg::BAL_HRESP_OKAY;
         addr_q <= next_addr_q;
         write_q <= next_write_q;
         instr <= next_instr;
         file_addr <= next_file_addr;
      end
   end

   // ----------------------------------------------------------------
   // Operation results
   // ----------------------------------------------------------------
   // f + ~W + C equals f - W - borrow; carry out is the no-borrow flag
   assign sub_sum = {1'b0, mem_rdata} + {1'b0, ~acc} + {8'h00, flags.c};
   assign sub_nib = {1'b0, mem_rdata[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, flags.c};
   assign swap_res = {mem_rdata[3:0], mem_rdata[7:4]};
   assign xor_file = acc ^ mem_rdata;

   // ----------------------------------------------------------------
   // Accumulator, flags and file write-back
   // ----------------------------------------------------------------
   always_comb
   begin
      next_acc = acc;
      next_flags = flags;
      mem_addr = file_addr;
      mem_wen = 1'b0;
      mem_wdata = hwdata[7:0];
      if (state == ST_DATA && write_q)
      begin
         case (addr_q)
            bal_pkg::BAL_REG_ACC: next_acc = hwdata[7:0];
            bal_pkg::BAL_REG_STATUS: next_flags = hwdata[2:0];
            bal_pkg::BAL_REG_FDATA: mem_wen = 1'b1;
            default: next_acc = acc;
         endcase
      end
      if (state == ST_EXRD || wb)
      begin
         mem_addr = instr.faddr;
      end
      if (wb)
      begin
         case (instr.op)
            bal_pkg::BAL_OP_SUBB:
            begin
               next_flags.c = sub_sum[8];
               next_flags.dc = sub_nib[4];
               next_flags.z = is_zero(sub_sum[7:0]);
               mem_wdata = sub_sum[7:0];
               mem_wen = instr.dest;
               next_acc = instr.dest ? acc : sub_sum[7:0];
            end
            bal_pkg::BAL_OP_SWAP:
            begin
               mem_wdata = swap_res;
               mem_wen = instr.dest;
               next_acc = instr.dest ? acc : swap_res;
            end
            bal_pkg::BAL_OP_XORL:
            begin
               next_acc = acc ^ instr.literal;
               next_flags.z = is_zero(acc ^ instr.literal);
            end
            bal_pkg::BAL_OP_XORF:
            begin
               next_flags.z = is_zero(xor_file);
               mem_wdata = xor_file;
               mem_wen = instr.dest;
               next_acc = instr.dest ? acc : xor_file;
            end
            default:
            begin
               next_acc = acc;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         acc <= bal_pkg::BAL_ACC_RESET;
         flags <= bal_pkg::BAL_FLAGS_RESET;
      end
      else
      begin
         acc <= next_acc;
         flags <= next_flags;
      end
   end

   // ----------------------------------------------------------------
   // Port direction registers
   // ----------------------------------------------------------------
   for (genvar i = 0; i < bal_pkg::BAL_NUM_PORTS; i++)
   begin : g_dir
      logic [7:0] next_dir;
      always_comb
      begin
         next_dir = dir[i];
         if (wb && instr.op == bal_pkg::BAL_OP_DIRLD && dir_hit(instr.faddr, i))
         begin
            next_dir = acc;
         end
      end
      always_ff @(posedge clk_sys or negedge nrst)
      begin
         if (!nrst)
         begin
            dir[i] <= bal_pkg::BAL_DIR_RESET;
         end
         else
         begin
            dir[i] <= next_dir;
         end
      end
   end

   assign port_a_direction = dir[0];
   assign port_b_direction = dir[1];
   assign port_c_direction = dir[2];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence instr_issue_s;
      state == ST_DATA && write_q && addr_q == bal_pkg::BAL_REG_INSTR;
   endsequence

   sequence exec_done_s;
      !hreadyout [*3] ##1 hreadyout;
   endsequence

   sequence wb_op_s(bal_pkg::bal_op_type o);
      wb && instr.op == o;
   endsequence

   exec_latency_a: assert property (instr_issue_s |-> exec_done_s)
      else $error("instruction write did not finish in four cycles");

   sub_value_a: assert property (wb_op_s(bal_pkg::BAL_OP_SUBB) |->
      mem_wdata == 8'(mem_rdata - acc - {7'h00, ~flags.c}))
      else $error("subtract with borrow result wrong");

   sub_dest_a: assert property (wb_op_s(bal_pkg::BAL_OP_SUBB) ##0 !instr.dest |=>
      acc == $past(mem_wdata) && $stable(u_ram.mem[instr.faddr]))
      else $error("subtract result not routed to accumulator");

   sub_carry_a: assert property (wb_op_s(bal_pkg::BAL_OP_SUBB) |=>
      flags.c == ($past({1'b0, mem_rdata}) >= $past({1'b0, acc}) + {8'h00, ~$past(flags.c)})
      && flags.dc == ($past({1'b0, mem_rdata[3:0]}) >= $past({1'b0, acc[3:0]}) + {4'h0, ~$past(flags.c)})
      && flags.z == ($past(mem_wdata) == 8'h00))
      else $error("subtract carry, digit carry or zero flag wrong");

   swap_a: assert property (wb_op_s(bal_pkg::BAL_OP_SWAP) |->
      mem_wdata[7:4] == mem_rdata[3:0] && mem_wdata[3:0] == mem_rdata[7:4] && mem_wen == instr.dest
      ##1 $stable(flags))
      else $error("nibble swap wrong or flags changed");

   swap_dest_a: assert property (wb_op_s(bal_pkg::BAL_OP_SWAP) ##0 !instr.dest |=>
      acc == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
      else $error("swap result missing from accumulator");

   dir_load_a: assert property (wb_op_s(bal_pkg::BAL_OP_DIRLD) ##0 instr.faddr == 7'h06 |=>
      port_b_direction == $past(acc) && $stable(port_a_direction) && $stable(port_c_direction) && $stable(flags))
      else $error("direction load to port b wrong");

   dir_keep_a: assert property (wb_op_s(bal_pkg::BAL_OP_DIRLD) ##0
      (instr.faddr < 7'h05 || instr.faddr > 7'h07) |=>
      $stable(port_a_direction) && $stable(port_b_direction) && $stable(port_c_direction) && $stable(flags))
      else $error("out of range direction load changed state");

   xorl_a: assert property (wb_op_s(bal_pkg::BAL_OP_XORL) |=>
      acc == ($past(acc) ^ $past(instr.literal)) && flags.z == (acc == 8'h00)
      && flags.c == $past(flags.c) && flags.dc == $past(flags.dc))
      else $error("literal xor wrong");

   xorf_a: assert property (wb_op_s(bal_pkg::BAL_OP_XORF) |=>
      flags.z == (($past(acc) ^ $past(mem_rdata)) == 8'h00) && flags.c == $past(flags.c)
      && flags.dc == $past(flags.dc)
      && acc == ($past(instr.dest) ? $past(acc) : ($past(acc) ^ $past(mem_rdata))))
      else $error("file xor wrong");

endmodule

// [verif/bal_core_model.sv]
// Core-side model: the instruction source that drives the byte ALU over
// AHB-Lite with single whole-word transfers.
// Assumes hready is the slave's hreadyout and callers start just after an edge.
`timescale 1ns/1ps
module bal_core_model
(
   // Clock
   input wire logic clk_sys,
   // AHB-Lite master
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata
);

   initial
   begin
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
   end

   // ----------------------------------------------------------------
   // One transfer: address phase, then data phase, each held to hready
   // ----------------------------------------------------------------
   task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do
         @(posedge clk_sys);
      while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do
         @(posedge clk_sys);
      while (hready !== 1'b1);
      rd = hrdata;
      // Released data lines never keep showing the last word
      hwdata <= ~wd;
   endtask

endmodule

// [verif/tb.sv]
// Self-checking bench for the byte ALU: register accesses and instruction
// sequences through the core model, compared with values worked out here.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module tb;

   // ----------------------------------------------------------------
   // Signals and tables
   // ----------------------------------------------------------------
   logic clk_sys;
   logic nrst;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic [31:0] hrdata;
   logic [1:0] hresp;
   logic [7:0] port_a_direction;
   logic [7:0] port_b_direction;
   logic [7:0] port_c_direction;
   logic [31:0] rv;
   logic [10:0] e;
   logic [23:0] dexp;
   int n_fail;
   int compares;
   int cycles = 0;
   logic [7:0] sf[4] = '{8'h50, 8'h20, 8'h35, 8'h10};
   logic [7:0] sw[4] = '{8'h20, 8'h50, 8'h34, 8'h01};
   logic sc[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
   logic sd[4] = '{1'b0, 1'b1, 1'b0, 1'b1};

   initial clk_sys = 1'b0;
   always #10 clk_sys = ~clk_sys;

   bal_core_model core_u (.clk_sys(clk_sys), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

   bal_alu dut_u (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .port_a_direction(port_a_direction),
      .port_b_direction(port_b_direction), .port_c_direction(port_c_direction));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task close_out;
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      core_u.xfer(a, 1'b1, d, rv);
   endtask

   task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      core_u.xfer(a, 1'b0, 32'h0000_0000, rv);
      chk(nm, exp, rv);
   endtask

   task exec(input logic [2:0] op, input logic d, input logic [6:0] f, input logic [7:0] k);
      wr(bal_pkg::BAL_REG_INSTR, {8'h00, k, 1'b0, f, 4'h0, d, op});
   endtask

   task setup(input logic [7:0] acc, input logic [2:0] st, input logic [6:0] f, input logic [7:0] fv);
      wr(bal_pkg::BAL_REG_ACC, {24'h00_0000, acc});
      wr(bal_pkg::BAL_REG_STATUS, {29'h0000_0000, st});
      wr(bal_pkg::BAL_REG_FADDR, {25'h000_0000, f});
      wr(bal_pkg::BAL_REG_FDATA, {24'h00_0000, fv});
   endtask

   task expect_state(input logic [7:0] acc, input logic [2:0] st, input logic [7:0] fv);
      rdc("acc", bal_pkg::BAL_REG_ACC, {24'h00_0000, acc});
      rdc("status", bal_pkg::BAL_REG_STATUS, {29'h0000_0000, st});
      rdc("file", bal_pkg::BAL_REG_FDATA, {24'h00_0000, fv});
   endtask

   // Result in 7:0, then carry, digit carry and zero; carry means no borrow
   function automatic logic [10:0] sub_exp(input logic [7:0] f, input logic [7:0] w, input logic c);
      logic [8:0] full;
      logic [4:0] low;
      full = {1'b0, f} - {1'b0, w} - {8'h00, ~c};
      low = {1'b0, f[3:0]} - {1'b0, w[3:0]} - {4'h0, ~c};
      return {(full[7:0] == 8'h00), ~low[4], ~full[8], full[7:0]};
   endfunction

   // ----------------------------------------------------------------
   // Timeout
   // ----------------------------------------------------------------
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         n_fail++;
         close_out;
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      nrst = 1'b0;
      n_fail = 0;
      compares = 0;
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      chk("ports_rst", 32'h00FF_FFFF, {8'h00, port_c_direction, port_b_direction, port_a_direction});
      rdc("acc_rst", bal_pkg::BAL_REG_ACC, 32'h0000_0000);
      rdc("status_rst", bal_pkg::BAL_REG_STATUS, 32'h0000_0000);
      rdc("unmapped", 8'h18, 32'h0000_0000);
      wr(bal_pkg::BAL_REG_DIR, 32'h0012_3456);
      rdc("dir_ro", bal_pkg::BAL_REG_DIR, 32'h00FF_FFFF);
      // Subtract with borrow, both destinations, borrow in and out
      for (int i = 0; i < 4; i++)
      begin
         setup(sw[i], {2'b10, sc[i]}, 7'h20, sf[i]);
         e = sub_exp(sf[i], sw[i], sc[i]);
         exec(bal_pkg::BAL_OP_SUBB, sd[i], 7'h20, 8'h00);
         expect_state(sd[i] ? sw[i] : e[7:0], e[10:8], sd[i] ? e[7:0] : sf[i]);
      end
      // Nibble swap to either destination with flags preset
      for (int d = 0; d < 2; d++)
      begin
         setup(8'h3C, 3'h5, 7'h21, 8'hA5);
         exec(bal_pkg::BAL_OP_SWAP, d[0], 7'h21, 8'h00);
         expect_state(d[0] ? 8'h3C : 8'h5A, 3'h5, d[0] ? 8'h5A : 8'hA5);
      end
      // Direction load across and around operands 5..7
      dexp = 24'hFF_FFFF;
      for (int f = 4; f < 9; f++)
      begin
         setup(8'h10 + f[7:0], 3'h2, 7'h22, 8'h00);
         exec(bal_pkg::BAL_OP_DIRLD, 1'b0, f[6:0], 8'h00);
         if (f >= 5 && f <= 7)
            dexp[8 * (f - 5) +: 8] = 8'h10 + f[7:0];
         rdc("dir", bal_pkg::BAL_REG_DIR, {8'h00, dexp});
         chk("ports", {8'h00, dexp}, {8'h00, port_c_direction, port_b_direction, port_a_direction});
         rdc("status_dir", bal_pkg::BAL_REG_STATUS, 32'h0000_0002);
      end
      // Literal XOR: zero result then non-zero, carry flags kept
      setup(8'h3C, 3'h3, 7'h23, 8'h77);
      exec(bal_pkg::BAL_OP_XORL, 1'b1, 7'h23, 8'h3C);
      expect_state(8'h00, 3'h7, 8'h77);
      exec(bal_pkg::BAL_OP_XORL, 1'b0, 7'h23, 8'hC3);
      expect_state(8'hC3, 3'h3, 8'h77);
      // File XOR to file then to accumulator
      setup(8'h0F, 3'h3, 7'h24, 8'h0F);
      exec(bal_pkg::BAL_OP_XORF, 1'b1, 7'h24, 8'h00);
      expect_state(8'h0F, 3'h7, 8'h00);
      wr(bal_pkg::BAL_REG_FDATA, 32'h0000_00F0);
      exec(bal_pkg::BAL_OP_XORF, 1'b0, 7'h24, 8'h00);
      expect_state(8'hFF, 3'h3, 8'hF0);
      // Unused codes 6, 7 and 0 leave everything alone
      for (int op = 6; op < 9; op++)
      begin
         exec(op[2:0], 1'b1, 7'h24, 8'hFF);
         expect_state(8'hFF, 3'h3, 8'hF0);
      end
      chk("hresp", 32'h0000_0000, {30'h0000_0000, hresp});
      close_out;
   end

endmodule
